// ---- rtl/swd_top.sv ----
// watchdog with axi4-lite control register and halt handling
// assumes aresetn is the chip reset that follows wdg_reset_n
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module swd_top
  import swd_pkg::*;
#(
  parameter int PRESCALE = SWD_PRESCALE,
  parameter int WAKE_CYC = SWD_WAKE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic opt_hw_wdg,
  input wire logic opt_halt_rst,
  input wire logic halt_exec,
  input wire logic ext_irq,
  output logic wdg_reset_n
);
  localparam int PRE_W = $clog2(PRESCALE);
  localparam int WK_W = $clog2(WAKE_CYC);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
  localparam logic [WK_W-1:0] WAKE_LAST = WK_W'(WAKE_CYC - 1);
  localparam logic [4:0] RST_LOAD = 5'(SWD_RST_CYC);

  // ***********************************
  // bus slave
  // ***********************************
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  wire wr_fire = aw_got && w_got && !s_axi_bvalid;
  wire wr_ctrl = wr_fire && aw_addr == SWD_ADDR_CTRL;
  wire wr_ok = aw_addr == SWD_ADDR_CTRL || aw_addr == SWD_ADDR_STAT;
  // a write changes the control byte only when lane 0 is written
  wire ctrl_wr = wr_ctrl && w_lane0;
  wire ar_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (wr_fire) aw_got <= 1'b0;
      if (!aw_got && !s_axi_bvalid) s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got <= 1'b1;
      w_data <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else begin
      if (wr_fire) w_got <= 1'b0;
      if (!w_got && !s_axi_bvalid) s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SWD_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? SWD_RESP_OKAY : SWD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ***********************************
  // watchdog core
  // ***********************************
  swd_opt_s opt;
  logic opt_done;
  logic act;
  logic [6:0] count;
  logic [PRE_W-1:0] pre;
  logic [WK_W-1:0] wake_cnt;
  logic [4:0] rst_cnt;
  swd_state_e state;
  swd_state_e next_state;

  wire active = opt.hw_wdg || act; // R7 R14
  // wait mode is not an input: counting pauses only in halt and during the wake delay
  wire tick = state == SWD_RUN && pre == PRE_LAST; // R1 R4 R8
  wire roll_trip = active && tick && !ctrl_wr && count == SWD_ROLL_VAL; // R2
  wire soft_trip = ctrl_wr && (active || w_data[SWD_ACT_BIT])
    && !w_data[SWD_TOP_BIT]; // R6
  wire halt_go = halt_exec && state == SWD_RUN;
  wire halt_trip = halt_go && opt.halt_rst && active; // R9
  wire trip = roll_trip || soft_trip || halt_trip;
  wire [7:0] stat_val = {3'h0, opt.halt_rst, opt.hw_wdg,
    state == SWD_WAKE, state == SWD_HALT, active};
  wire [7:0] rd_byte = s_axi_araddr == SWD_ADDR_CTRL ? {act, count}
    : s_axi_araddr == SWD_ADDR_STAT ? stat_val : 8'h00;
  wire rd_ok = s_axi_araddr == SWD_ADDR_CTRL || s_axi_araddr == SWD_ADDR_STAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SWD_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_ok ? SWD_RESP_OKAY : SWD_RESP_SLVERR;
    end else begin
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (!s_axi_rvalid && !s_axi_arready) s_axi_arready <= 1'b1;
    end
  end

  // options are straps, caught once on the first edge after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opt <= '0;
      opt_done <= 1'b0;
    end else if (!opt_done) begin
      opt <= '{hw_wdg: opt_hw_wdg, halt_rst: opt_halt_rst};
      opt_done <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act <= SWD_CTRL_RESET[SWD_ACT_BIT]; // R13 R5
      count <= SWD_CTRL_RESET[6:0]; // R13
    end else if (ctrl_wr) begin
      act <= act || w_data[SWD_ACT_BIT]; // R14 R5
      count <= w_data[6:0]; // R15
    end else if (tick) begin
      count <= count - 7'h01; // R1
    end
  end

  // a fixed prescaler keeps the timeout in 64 coarse steps
  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_wr || tick) pre <= '0; // R15
    else if (state == SWD_RUN) pre <= pre + PRE_W'(1); // R10
  end

  always_comb begin
    next_state = state;
    case (state)
      SWD_RUN: if (halt_go && !halt_trip) next_state = SWD_HALT; // R10
      SWD_HALT: if (ext_irq) next_state = SWD_WAKE; // R10
      SWD_WAKE: if (wake_cnt == WAKE_LAST) next_state = SWD_RUN; // R11
      default: next_state = SWD_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SWD_RUN; // R11
      wake_cnt <= '0;
    end else begin
      state <= next_state;
      wake_cnt <= state == SWD_WAKE ? wake_cnt + WK_W'(1) : '0; // R11
    end
  end

  // the pulse outlives a reset it causes only if aresetn comes later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt <= 5'h00;
      wdg_reset_n <= 1'b1;
    end else begin
      if (trip) rst_cnt <= RST_LOAD; // R2
      else if (rst_cnt != 5'h00) rst_cnt <= rst_cnt - 5'h01;
      wdg_reset_n <= !(trip || rst_cnt > 5'h01); // R2
    end
  end

  // ***********************************
  // assertions
  // ***********************************
  logic [4:0] low_len;
  always_ff @(posedge aclk) begin
    if (!aresetn || wdg_reset_n) low_len <= 5'h00;
    else if (low_len != 5'h1F) low_len <= low_len + 5'h01;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_roll;
    tick && !ctrl_wr && count == SWD_ROLL_VAL;
  endsequence
  sequence s_low_pulse;
    !wdg_reset_n [*8];
  endsequence

  AST_PRESCALE_STEP: assert property ( // R1
    tick && !ctrl_wr |=> count == $past(count) - 7'h01 && pre == '0)
    else $error("count did not step on prescaler tick");
  AST_ROLL_RESET: assert property ( // R2
    s_roll and active |=> s_low_pulse)
    else $error("rollover from 40h did not start a reset pulse");
  AST_PULSE_LEN: assert property ( // R2
    $rose(wdg_reset_n) |-> $past(low_len) >= 5'(SWD_RST_CYC - 1))
    else $error("reset pulse shorter than its minimum");
  AST_STAYS_ON: assert property ( // R5
    act |=> act)
    else $error("activation bit cleared without reset");
  AST_SOFT_RST: assert property ( // R6
    ctrl_wr && w_data[SWD_ACT_BIT] && !w_data[SWD_TOP_BIT] |=> !wdg_reset_n)
    else $error("software reset write had no effect");
  AST_HW_ACTIVE: assert property ( // R7
    s_roll and opt.hw_wdg && !act |=> !wdg_reset_n)
    else $error("hardware option did not force activity");
  AST_IDLE_QUIET: assert property ( // R14
    s_roll and !active && opt_done && rst_cnt == 5'h00 && !halt_go |=> wdg_reset_n)
    else $error("inactive watchdog produced a reset");
  AST_HALT_RST: assert property ( // R9
    halt_go && opt.halt_rst && active |=> !wdg_reset_n && state == SWD_RUN)
    else $error("halt with option did not reset");
  AST_HALT_FROZEN: assert property ( // R10
    state == SWD_HALT && !ctrl_wr |=> count == $past(count) && $stable(pre))
    else $error("counter moved during halt");
  AST_WAKE_DELAY: assert property ( // R11
    $rose(state == SWD_RUN) && $past(state) == SWD_WAKE |-> $past(wake_cnt) == WAKE_LAST)
    else $error("wake delay length wrong");
  AST_LOAD: assert property ( // R15
    ctrl_wr |=> count == $past(w_data[6:0]) && pre == '0)
    else $error("control write did not load the count");
  AST_RESET_VAL: assert property (@(posedge aclk) disable iff (1'b0) // R13
    !aresetn |=> {act, count} == SWD_CTRL_RESET && wdg_reset_n)
    else $error("control reset value wrong");

  // ***********************************
  // bus and halt guards
  // ***********************************
  // answers must stand until the master takes them
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  AST_R_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");
  // one write and one read in flight at most
  AST_ONE_WRITE: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write offered while response pending");
  AST_ONE_READ: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("new read offered while data pending");
  AST_READ_ANSWER: assert property (
    ar_fire |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle after address");
  AST_WRITE_ANSWER: assert property (
    wr_fire |=> s_axi_bvalid)
    else $error("write not answered after address and data");
  // a halted or waking watchdog must neither count nor reset
  AST_HALT_QUIET: assert property ( // R10
    state == SWD_HALT && rst_cnt == 5'h00 && !ctrl_wr |=> wdg_reset_n)
    else $error("halted watchdog produced a reset");
  AST_WAKE_FROZEN: assert property ( // R11
    state == SWD_WAKE && !ctrl_wr |=> $stable(pre) && count == $past(count))
    else $error("counter moved before wake delay ended");
  // straps are static once caught
  AST_STRAPS: assert property ( // R7 R9
    opt_done |=> $stable(opt))
    else $error("option straps changed after capture");
endmodule // swd_top

// ---- rtl/swd_pkg.sv ----
// constants, types and field layout of the software fault watchdog
// assumes one 40 MHz clock standing in for the cpu machine cycle
// Functional notes
// R1 - countdown decrements once every 49,152 machine cycles; 64 programmable steps
// R2 - active and count going 40h to 3Fh pulls reset low about 500 ns
// R3 - software rewrites control periodically with a value from FFh to C0h
// R4 - at 8 MHz, FFh gives 393.216 ms and C0h gives 6.144 ms
// R5 - software mode: disabled after reset; once active, only reset disables
// R6 - write with activation set and top bit clear resets at once
// R7 - hardware option: always active, activation bit ignored
// R8 - wait mode has no effect on the watchdog
// R9 - reset-on-halt option and active: halt causes immediate reset
// R10 - otherwise halt stops counting and resets until interrupt or reset
// R11 - after interrupt wake, counting resumes 4096 clocks later
// R12 - software should reload the counter before executing halt
// R13 - control: activation bit 7, count bits 6 to 0, reset 7Fh
// R14 - activation bit set by software, cleared by reset only; gates resets
// R15 - a control write loads count at once and restarts the prescaler
package swd_pkg;
  localparam logic [7:0] SWD_ADDR_CTRL = 8'h0C;
  localparam logic [7:0] SWD_ADDR_STAT = 8'h10;
  localparam logic [7:0] SWD_CTRL_RESET = 8'h7F;
  localparam int SWD_ACT_BIT = 7;
  localparam int SWD_TOP_BIT = 6;
  localparam logic [6:0] SWD_ROLL_VAL = 7'h40;
  localparam int SWD_PRESCALE = 49152;
  localparam int SWD_WAKE_CYC = 4096;
  localparam int SWD_CLK_NS = 25;
  localparam int SWD_RST_PULSE_NS = 500;
  localparam int SWD_RST_CYC = (SWD_RST_PULSE_NS + SWD_CLK_NS - 1) / SWD_CLK_NS;
  localparam logic [1:0] SWD_RESP_OKAY = 2'h0;
  localparam logic [1:0] SWD_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SWD_RUN, SWD_HALT, SWD_WAKE} swd_state_e;
  typedef struct packed {
    logic hw_wdg;
    logic halt_rst;
  } swd_opt_s;
endpackage

// ---- dv/test_swd_top.sv ----
// directed self-checking bench for the software fault watchdog
// assumes swd_pkg is compiled first; the bench itself plays the chip reset
`timescale 1ns/100ps
module test_swd_top;
  import swd_pkg::*;
  localparam int PRE = 8;
  localparam int WK = 4;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic hw = 0, hr = 0, halt = 0, irq = 0;
  logic awready, wready, bvalid, arready, rvalid, rst_n;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int failures = 0;
  int num_checks = 0;
  always #12.5 aclk = ~aclk;
  swd_top #(.PRESCALE(PRE), .WAKE_CYC(WK)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .opt_hw_wdg(hw), .opt_halt_rst(hr), .halt_exec(halt),
    .ext_irq(irq), .wdg_reset_n(rst_n));
  // ****************
  // shared tasks
  // ****************
  task stop_test;
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // straps must be steady before release, they are sampled right after it
  task rs(input logic h, input logic q);
    aresetn <= 0;
    hw <= h;
    hr <= q;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 0;
    if (i == 50) begin
      failures++;
      stop_test();
    end
  endtask
  task rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 0;
    if (i == 50) begin
      failures++;
      stop_test();
    end
  endtask
  // bounded wait for the reset pulse, then measure how long it stays low
  task trip(input int lo, input int hi);
    int n, k;
    for (n = 0; n <= hi && rst_n; n++) @(posedge aclk);
    chk("trip_delay_ok", 32'(n >= lo && n <= hi), 32'h1);
    for (k = 0; k < 100 && !rst_n; k++) @(posedge aclk);
    chk("pulse_cycles", 32'(k), 32'(SWD_RST_CYC));
  endtask
  task quiet(input int n);
    logic low;
    low = 0;
    repeat (n) begin
      @(posedge aclk);
      low |= !rst_n;
    end
    chk("no_trip", 32'(low), 32'h0);
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    rs(0, 0);
    rd(SWD_ADDR_CTRL);
    chk("ctrl_reset", d, 32'h7F);
    rd(SWD_ADDR_STAT);
    chk("stat_reset", d, 32'h0);
    chk("stat_resp", 32'(r), 32'(SWD_RESP_OKAY));
    wr(8'h20, 8'hC0);
    chk("unmapped_resp", 32'(r), 32'(SWD_RESP_SLVERR));
    rd(SWD_ADDR_CTRL);
    chk("act_after_bad", 32'(d[7]), 32'h0);
    quiet(600);
    wr(SWD_ADDR_CTRL, 8'hC0);
    chk("ctrl_wr_resp", 32'(r), 32'(SWD_RESP_OKAY));
    trip(PRE - 1, PRE + 3);
    rs(0, 0);
    wr(SWD_ADDR_CTRL, 8'hFF);
    wr(SWD_ADDR_CTRL, 8'h7F);
    rd(SWD_ADDR_CTRL);
    chk("act_sticky", 32'(d[7]), 32'h1);
    rs(0, 0);
    wr(SWD_ADDR_CTRL, 8'h80);
    trip(0, 3);
    rs(1, 0);
    rd(SWD_ADDR_STAT);
    chk("stat_hw_active", d, 32'h09);
    trip(64 * PRE - 12, 64 * PRE + 4);
    rs(0, 0);
    wr(SWD_ADDR_CTRL, 8'hC1);
    halt <= 1;
    @(posedge aclk);
    halt <= 0;
    quiet(100);
    rd(SWD_ADDR_STAT);
    chk("stat_halted", d, 32'h03);
    irq <= 1;
    @(posedge aclk);
    irq <= 0;
    trip(WK + PRE, WK + 2 * PRE + 4);
    rs(0, 1);
    wr(SWD_ADDR_CTRL, 8'hFF);
    halt <= 1;
    @(posedge aclk);
    halt <= 0;
    trip(0, 3);
    stop_test();
  end
endmodule // test_swd_top
